/* File: rtl/dma_pkg.sv */
// Constants, types and register layout of the two-channel cycle-stealing transfer engine
package dma_pkg;

	localparam int ADDR_W = 20;
	localparam int N_PERIPH = 20;

	// Register map: bit 5 of the address picks the channel
	localparam int CH_BIT = 5;
	localparam logic [4:0] OFS_SRC = 5'h00;
	localparam logic [4:0] OFS_DST = 5'h04;
	localparam logic [4:0] OFS_RELOAD = 5'h08;
	localparam logic [4:0] OFS_CTRL = 5'h0C;
	localparam logic [4:0] OFS_COUNT = 5'h10;

	// Control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_UNIT8 = 1;
	localparam int CTRL_REPEAT = 2;
	localparam int CTRL_SRC_FWD = 3;
	localparam int CTRL_DST_FWD = 4;
	localparam int CTRL_REQ = 5;
	localparam int CTRL_SWTRIG = 6;
	localparam int CTRL_SEL = 8;

	// Trigger selection codes
	localparam logic [4:0] SEL_SOFT = 5'h00;
	localparam logic [4:0] SEL_EXT0_FALL = 5'h01;
	localparam logic [4:0] SEL_EXT0_BOTH = 5'h02;
	localparam logic [4:0] SEL_EXT1_FALL = 5'h03;
	localparam logic [4:0] SEL_EXT1_BOTH = 5'h04;
	localparam logic [4:0] SEL_PERIPH_BASE = 5'h05;

	// Address areas and access timing
	localparam logic [19:0] REGS_LO = 20'h0_0020;
	localparam logic [19:0] REGS_HI = 20'h0_003F;
	localparam logic [19:0] SFR_TOP = 20'h0_03FF;
	localparam logic [1:0] WAIT_EXTRA = 2'h1;
	localparam logic [19:0] STEP_BYTE = 20'h0_0001;
	localparam logic [19:0] STEP_WORD = 20'h0_0002;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_GAP = 4'b1000
	} fsm_e;

	typedef struct packed {
		logic enable;
		logic need_reload;
		logic unit8;
		logic repeat_mode;
		logic src_fwd;
		logic dst_fwd;
		logic req;
		logic [4:0] sel;
		logic [19:0] src;
		logic [19:0] dst;
		logic [19:0] fwd_ptr;
		logic [15:0] reload;
		logic [15:0] count;
	} chan_s;

	typedef struct packed {
		logic [19:0] addr;
		logic wide;
		logic two;
		logic [1:0] wait_cnt;
		logic blocked;
	} acc_s;

	typedef struct packed {
		fsm_e fsm;
		logic act;
		logic part;
		acc_s acc;
		logic [19:0] dbase;
		logic [15:0] data;
		chan_s [1:0] ch;
		logic [1:0] ext_s1;
		logic [1:0] ext_s2;
		logic [1:0] ext_d;
		logic byte_s1;
		logic byte_s2;
		logic [31:0] rdata;
		logic [15:0] mem_wdata;
		logic mem_rd;
		logic mem_wr;
		logic bus_own;
		logic [1:0] irq;
	} core_s;

endpackage

/* File: rtl/two_channel_cycle_steal_dma.sv */
// Two-channel cycle-stealing transfer engine with register port and bus master side
module two_channel_cycle_steal_dma import dma_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_ext_irq_pin_zero,
	input wire logic i_ext_irq_pin_one,
	input wire logic [N_PERIPH-1:0] i_periph_irq,
	input wire logic i_byte_pin,
	input wire logic i_exp_mode,
	input wire logic i_sw_wait,
	input wire logic [15:0] i_mem_rdata,
	output logic o_bus_own,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic o_mem_wide,
	output logic [19:0] o_mem_addr,
	output logic [15:0] o_mem_wdata,
	output logic [1:0] o_irq
);

	core_s st;
	core_s nx;
	logic [1:0] go;
	logic [1:0] trig;
	logic unit_end;
	logic byte8;
	logic ci;
	logic c;
	logic mapped;
	logic [4:0] ofs;
	logic [4:0] pidx;
	logic [19:0] ptr;

	// Plan one bus access: width, split, wait and register-range guard
	function automatic acc_s plan_acc(input logic [19:0] a, input logic u8, input logic b8,
		input logic sw);
		acc_s p;
		p.addr = a;
		// odd word start forces a split
		p.wide = !u8 && !b8 && !a[0];
		p.two = !u8 && !p.wide;
		p.wait_cnt = (a <= SFR_TOP || sw) ? WAIT_EXTRA : 2'h0;
		p.blocked = (a >= REGS_LO) && (a <= REGS_HI);
		return p;
	endfunction

	// Start value of whichever pointer runs forward
	function automatic logic [19:0] fwd_start(input chan_s ch);
		return ch.src_fwd ? ch.src : ch.dst;
	endfunction

	// All outputs straight from the state register
	assign o_rdata = st.rdata;
	assign o_bus_own = st.bus_own;
	assign o_mem_rd = st.mem_rd;
	assign o_mem_wr = st.mem_wr;
	assign o_mem_wide = st.acc.wide;
	assign o_mem_addr = st.acc.addr;
	assign o_mem_wdata = st.mem_wdata;
	assign o_irq = st.irq;

	// Next-state logic for the whole block
	always_comb begin
		nx = st;
		trig = 2'h0;
		unit_end = 1'b0;
		pidx = 5'h00;
		ptr = 20'h0_0000;
		c = 1'b0;
		ci = i_addr[CH_BIT];
		ofs = i_addr[4:0];
		mapped = (i_addr[7:6] == 2'h0);
		nx.irq = 2'h0;
		nx.rdata = 32'h0000_0000;
		// Pins pass two flops before edge detection
		nx.ext_s1 = {i_ext_irq_pin_one, i_ext_irq_pin_zero};
		nx.ext_s2 = st.ext_s1;
		nx.ext_d = st.ext_s2;
		nx.byte_s1 = i_byte_pin;
		nx.byte_s2 = st.byte_s1;
		// byte pin width applies to every area
		byte8 = st.byte_s2 & i_exp_mode;
		go[0] = st.ch[0].enable & st.ch[0].req;
		go[1] = st.ch[1].enable & st.ch[1].req;

		case (st.fsm)
			ST_IDLE: begin
				if (go != 2'h0) begin
					c = !go[0];
					nx.act = c;
					// request drops as the unit starts
					nx.ch[c].req = 1'b0;
					ptr = st.ch[c].need_reload ? fwd_start(st.ch[c]) : st.ch[c].fwd_ptr;
					// reload only at first unit after enable
					if (st.ch[c].need_reload) begin
						// copy forward start and reload count
						nx.ch[c].fwd_ptr = fwd_start(st.ch[c]);
						nx.ch[c].count = st.ch[c].reload;
						nx.ch[c].need_reload = 1'b0;
					end
					// forward side uses the working pointer
					nx.acc = plan_acc(st.ch[c].src_fwd ? ptr : st.ch[c].src, st.ch[c].unit8,
						byte8, i_sw_wait);
					nx.dbase = st.ch[c].dst_fwd ? ptr : st.ch[c].dst;
					nx.part = 1'b0;
					nx.mem_rd = !nx.acc.blocked;
					// take the bus for this unit
					nx.bus_own = 1'b1;
					nx.fsm = ST_READ;
				end
			end
			ST_READ: begin
				if (st.acc.wait_cnt != 2'h0) begin
					nx.acc.wait_cnt = st.acc.wait_cnt - 2'h1;
				end else begin
					if (st.acc.wide) begin
						nx.data = i_mem_rdata;
					end else if (st.part) begin
						nx.data[15:8] = i_mem_rdata[7:0];
					end else begin
						nx.data[7:0] = i_mem_rdata[7:0];
					end
					if (st.acc.two && !st.part) begin
						nx.part = 1'b1;
						nx.acc = plan_acc(st.acc.addr + STEP_BYTE, 1'b1, byte8, i_sw_wait);
						nx.acc.two = 1'b1;
						nx.mem_rd = !nx.acc.blocked;
					end else begin
						// source read done, destination write follows
						nx.part = 1'b0;
						nx.acc = plan_acc(st.dbase, st.ch[st.act].unit8, byte8, i_sw_wait);
						nx.mem_rd = 1'b0;
						nx.mem_wr = !nx.acc.blocked;
						nx.mem_wdata = nx.acc.wide ? nx.data : {8'h00, nx.data[7:0]};
						nx.fsm = ST_WRITE;
					end
				end
			end
			ST_WRITE: begin
				if (st.acc.wait_cnt != 2'h0) begin
					nx.acc.wait_cnt = st.acc.wait_cnt - 2'h1;
				end else if (st.acc.two && !st.part) begin
					nx.part = 1'b1;
					nx.acc = plan_acc(st.acc.addr + STEP_BYTE, 1'b1, byte8, i_sw_wait);
					nx.acc.two = 1'b1;
					nx.mem_wr = !nx.acc.blocked;
					nx.mem_wdata = {8'h00, st.data[15:8]};
				end else begin
					unit_end = 1'b1;
					nx.part = 1'b0;
					nx.mem_wr = 1'b0;
					// hand the bus back before any next unit
					nx.bus_own = 1'b0;
					nx.fsm = ST_GAP;
					nx.ch[st.act].fwd_ptr = st.ch[st.act].fwd_ptr +
						(st.ch[st.act].unit8 ? STEP_BYTE : STEP_WORD);
					if (st.ch[st.act].count == 16'h0000) begin
						nx.irq[st.act] = 1'b1;
						if (st.ch[st.act].repeat_mode) begin
							// repeat keeps running from the start
							nx.ch[st.act].count = st.ch[st.act].reload;
							nx.ch[st.act].fwd_ptr = fwd_start(st.ch[st.act]);
						end else begin
							nx.ch[st.act].enable = 1'b0;
						end
					end else begin
						nx.ch[st.act].count = st.ch[st.act].count - 16'h0001;
					end
				end
			end
			ST_GAP: begin
				// CPU gets at least this cycle and the idle one
				nx.fsm = ST_IDLE;
			end
			default: begin
				nx.fsm = ST_IDLE;
				nx.mem_rd = 1'b0;
				nx.mem_wr = 1'b0;
				nx.bus_own = 1'b0;
			end
		endcase

		// Register writes land after the engine so a restart wins
		if (i_wr && mapped) begin
			case (ofs)
				OFS_SRC: begin
					if (st.ch[ci].src_fwd || !st.ch[ci].enable) begin
						nx.ch[ci].src = i_wdata[ADDR_W-1:0];
					end
				end
				OFS_DST: begin
					if (st.ch[ci].dst_fwd || !st.ch[ci].enable) begin
						nx.ch[ci].dst = i_wdata[ADDR_W-1:0];
					end
				end
				OFS_RELOAD: begin
					nx.ch[ci].reload = i_wdata[15:0];
				end
				OFS_CTRL: begin
					nx.ch[ci].enable = i_wdata[CTRL_EN];
					// writing 1 again restarts from scratch
					if (i_wdata[CTRL_EN]) begin
						nx.ch[ci].need_reload = 1'b1;
					end
					nx.ch[ci].unit8 = i_wdata[CTRL_UNIT8];
					nx.ch[ci].repeat_mode = i_wdata[CTRL_REPEAT];
					nx.ch[ci].src_fwd = i_wdata[CTRL_SRC_FWD];
					nx.ch[ci].dst_fwd = i_wdata[CTRL_DST_FWD];
					nx.ch[ci].sel = i_wdata[CTRL_SEL +: 5];
					// software can clear the flag only
					if (!i_wdata[CTRL_REQ]) begin
						nx.ch[ci].req = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// no interrupt enable or level is consulted
		for (int k = 0; k < 2; k++) begin
			pidx = st.ch[k].sel - SEL_PERIPH_BASE;
			case (st.ch[k].sel)
				SEL_SOFT: trig[k] = i_wr && mapped && (ofs == OFS_CTRL) && (ci == 1'(k)) &&
					i_wdata[CTRL_SWTRIG];
				SEL_EXT0_FALL: trig[k] = st.ext_d[0] & !st.ext_s2[0];
				SEL_EXT0_BOTH: trig[k] = st.ext_d[0] ^ st.ext_s2[0];
				SEL_EXT1_FALL: trig[k] = st.ext_d[1] & !st.ext_s2[1];
				SEL_EXT1_BOTH: trig[k] = st.ext_d[1] ^ st.ext_s2[1];
				default: trig[k] = (pidx < 5'(N_PERIPH)) && i_periph_irq[pidx];
			endcase
			// set wins over clear, even when disabled
			if (trig[k]) begin
				nx.ch[k].req = 1'b1;
			end
		end

		// Register reads, data in the following cycle only
		if (i_rd && mapped) begin
			case (ofs)
				OFS_SRC: begin
					nx.rdata[19:0] = (st.ch[ci].enable && st.ch[ci].src_fwd &&
						!st.ch[ci].need_reload) ? st.ch[ci].fwd_ptr : st.ch[ci].src;
				end
				OFS_DST: begin
					nx.rdata[19:0] = (st.ch[ci].enable && st.ch[ci].dst_fwd &&
						!st.ch[ci].need_reload) ? st.ch[ci].fwd_ptr : st.ch[ci].dst;
				end
				OFS_RELOAD: nx.rdata[15:0] = st.ch[ci].reload;
				OFS_COUNT: nx.rdata[15:0] = st.ch[ci].count;
				OFS_CTRL: begin
					nx.rdata[CTRL_EN] = st.ch[ci].enable;
					nx.rdata[CTRL_UNIT8] = st.ch[ci].unit8;
					nx.rdata[CTRL_REPEAT] = st.ch[ci].repeat_mode;
					nx.rdata[CTRL_SRC_FWD] = st.ch[ci].src_fwd;
					nx.rdata[CTRL_DST_FWD] = st.ch[ci].dst_fwd;
					nx.rdata[CTRL_REQ] = st.ch[ci].req;
					nx.rdata[CTRL_SEL +: 5] = st.ch[ci].sel;
				end
				default: begin
				end
			endcase
		end
	end

	// State register, synchronous reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			st <= '0;
			st.fsm <= ST_IDLE;
			// Pins idle high, so zeros here would fake an edge after reset
			st.ext_s1 <= 2'h3;
			st.ext_s2 <= 2'h3;
			st.ext_d <= 2'h3;
		end else begin
			st <= nx;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	sequence s_cpu_slot;
		!o_bus_own [*2];
	endsequence

	sequence s_ch0_start;
		st.fsm == ST_READ && st.act == 1'b0 && o_bus_own;
	endsequence

	property p_disabled_idle;
		st.fsm == ST_IDLE && !st.ch[0].enable && !st.ch[1].enable |=> st.fsm == ST_IDLE;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("disabled channel moved");

	property p_ch0_first;
		st.fsm == ST_IDLE && go == 2'b11 |=> s_ch0_start;
	endproperty
	a_ch0_first: assert property (p_ch0_first) else $error("channel one won a tie");

	property p_single_off;
		unit_end && st.ch[st.act].count == 16'h0000 && !st.ch[st.act].repeat_mode && !i_wr
			|=> !st.ch[$past(st.act)].enable;
	endproperty
	a_single_off: assert property (p_single_off) else $error("single mode stayed on");

	property p_repeat_reload;
		unit_end && st.ch[st.act].count == 16'h0000 && st.ch[st.act].repeat_mode && !i_wr
			|=> st.ch[$past(st.act)].enable &&
			st.ch[$past(st.act)].count == st.ch[$past(st.act)].reload;
	endproperty
	a_repeat_reload: assert property (p_repeat_reload) else $error("repeat not reloaded");

	property p_irq_underflow;
		unit_end && st.ch[st.act].count == 16'h0000 |=> o_irq[$past(st.act)] ##1 o_irq == 2'h0;
	endproperty
	a_irq_underflow: assert property (p_irq_underflow) else $error("irq not pulsed");

	property p_set_wins;
		i_wr && i_addr == {3'h0, OFS_CTRL} && !i_wdata[CTRL_REQ] && trig[0] |=> st.ch[0].req;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("trigger lost to clear");

	property p_cpu_slot;
		unit_end |=> s_cpu_slot;
	endproperty
	a_cpu_slot: assert property (p_cpu_slot) else $error("bus not returned to cpu");

	property p_read_fwd;
		i_rd && i_addr == {3'h0, OFS_SRC} && st.ch[0].enable && st.ch[0].src_fwd &&
			!st.ch[0].need_reload |=> o_rdata[19:0] == $past(st.ch[0].fwd_ptr);
	endproperty
	a_read_fwd: assert property (p_read_fwd) else $error("forward read not working ptr");

	property p_no_regs;
		(o_mem_wr || o_mem_rd) |-> !(o_mem_addr >= REGS_LO && o_mem_addr <= REGS_HI);
	endproperty
	a_no_regs: assert property (p_no_regs) else $error("own registers accessed");

	property p_sfr_wait;
		$rose(o_mem_rd) && o_mem_addr <= SFR_TOP |-> o_mem_rd [*2];
	endproperty
	a_sfr_wait: assert property (p_sfr_wait) else $error("special area wait missing");

	property p_byte_split;
		st.fsm == ST_IDLE && go[0] && byte8 && !st.ch[0].unit8 |=> st.acc.two && !o_mem_wide;
	endproperty
	a_byte_split: assert property (p_byte_split) else $error("byte bus not split");

	property p_fixed_lock;
		i_wr && i_addr == {3'h0, OFS_DST} && st.ch[0].enable && !st.ch[0].dst_fwd
			|=> st.ch[0].dst == $past(st.ch[0].dst);
	endproperty
	a_fixed_lock: assert property (p_fixed_lock) else $error("fixed pointer overwritten");

	property p_reload_start;
		st.fsm == ST_IDLE && go[0] && st.ch[0].need_reload
			|=> st.ch[0].count == $past(st.ch[0].reload);
	endproperty
	a_reload_start: assert property (p_reload_start) else $error("count not reloaded");

	property p_req_drop;
		st.fsm == ST_IDLE && go[0] && !trig[0] |=> !st.ch[0].req;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("request flag kept at start");

endmodule

/* File: verif/mem_model.sv */
// Far-side memory model: answers engine reads and logs engine writes
module mem_model (
	input wire logic i_clk_sys,
	input wire logic i_mem_rd,
	input wire logic i_mem_wr,
	input wire logic i_mem_wide,
	input wire logic [19:0] i_mem_addr,
	input wire logic [15:0] i_mem_wdata,
	input wire logic i_bus_own,
	output logic [15:0] o_mem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [15:0] idle_pat = 16'h0F0F;
	logic was_wr = 1'b0;
	logic was_own = 1'b0;
	logic [19:0] last_a = 20'h0_0000;
	logic [19:0] wa [32];
	logic [15:0] wd [32];
	int wn = 0;
	int rc = 0;
	int ownr = 0;

	// Byte content is a fixed function of its address
	function automatic logic [7:0] bv(input logic [19:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction

	// A released bus flips every cycle so stale data never looks valid
	assign o_mem_rdata = !i_mem_rd ? idle_pat :
		i_mem_wide ? {bv(i_mem_addr + 20'h0_0001), bv(i_mem_addr)} :
		{idle_pat[15:8], bv(i_mem_addr)};

	// One log entry per write access; a write strobe held on one address is one access
	always @(posedge i_clk_sys) begin
		idle_pat <= ~idle_pat;
		was_wr <= i_mem_wr;
		was_own <= i_bus_own;
		last_a <= i_mem_addr;
		if (i_mem_rd) rc <= rc + 1;
		if (i_bus_own && !was_own) ownr <= ownr + 1;
		if (i_mem_wr && (!was_wr || i_mem_addr != last_a) && wn < 32) begin
			wa[wn] <= i_mem_addr;
			wd[wn] <= i_mem_wide ? i_mem_wdata : {8'h00, i_mem_wdata[7:0]};
			wn <= wn + 1;
		end
	end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench: register tasks, trigger sources and far-side checks
module tb_top import dma_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [31:0] EN = 32'h0000_0001 << CTRL_EN;
	localparam logic [31:0] RP = 32'h0000_0001 << CTRL_REPEAT;
	localparam logic [31:0] SF = 32'h0000_0001 << CTRL_SRC_FWD;
	localparam logic [31:0] DF = 32'h0000_0001 << CTRL_DST_FWD;
	localparam logic [31:0] RQ = 32'h0000_0001 << CTRL_REQ;
	localparam logic [31:0] SW = 32'h0000_0001 << CTRL_SWTRIG;
	localparam logic [31:0] S6 = 32'(SEL_PERIPH_BASE + 5'h01) << CTRL_SEL;
	localparam logic [31:0] S7 = 32'(SEL_PERIPH_BASE + 5'h02) << CTRL_SEL;
	localparam logic [31:0] SP0 = 32'(SEL_EXT0_FALL) << CTRL_SEL;
	localparam logic [31:0] U8 = 32'h0000_0001 << CTRL_UNIT8;
	localparam logic [31:0] S0B = 32'(SEL_EXT0_BOTH) << CTRL_SEL;
	localparam logic [31:0] S1F = 32'(SEL_EXT1_FALL) << CTRL_SEL;
	localparam logic [31:0] S1B = 32'(SEL_EXT1_BOTH) << CTRL_SEL;

	logic clk;
	logic rst_n;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic pin0;
	logic pin1;
	logic [19:0] periph;
	logic byte_pin;
	logic exp_mode;
	logic sw_wait;
	logic [15:0] mem_rdata;
	logic bus_own;
	logic mem_rd;
	logic mem_wr;
	logic mem_wide;
	logic [19:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [1:0] irq;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	int irq0 = 0;
	int irq1 = 0;

	two_channel_cycle_steal_dma DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_irq_pin_zero(pin0),
		.i_ext_irq_pin_one(pin1), .i_periph_irq(periph), .i_byte_pin(byte_pin),
		.i_exp_mode(exp_mode), .i_sw_wait(sw_wait), .i_mem_rdata(mem_rdata),
		.o_bus_own(bus_own), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_wide(mem_wide),
		.o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_irq(irq));

	mem_model mem (.i_clk_sys(clk), .i_mem_rd(mem_rd), .i_mem_wr(mem_wr),
		.i_mem_wide(mem_wide), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
		.i_bus_own(bus_own), .o_mem_rdata(mem_rdata));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Interrupt pulses counted per channel; the cycle ceiling stops a hang
	always @(posedge clk) begin
		cyc++;
		if (irq[0] === 1'b1) irq0++;
		if (irq[1] === 1'b1) irq1++;
		if (cyc == 4000) begin
			failures++;
			results();
		end
	end

	function automatic logic [7:0] bv(input logic [19:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction

	task automatic results();
		if (failures == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Hi bits pick the channel, 3'b110 lands outside the map
	task automatic reg_wr(input logic [2:0] hi, input logic [4:0] ofs, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= {hi, ofs};
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [2:0] hi, input logic [4:0] ofs, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= {hi, ofs};
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask

	task automatic pulse(input logic [19:0] m);
		@(posedge clk);
		periph <= m;
		@(posedge clk);
		periph <= 20'h0_0000;
	endtask

	// Long enough for a delayed pin trigger, longer than the two-cycle CPU gap
	task automatic quiet();
		int k;
		k = 0;
		repeat (60) begin
			@(posedge clk);
			k = (bus_own === 1'b0) ? k + 1 : 0;
			if (k == 10) break;
		end
	endtask

	// One channel-zero unit, checked at the far side
	task automatic one0(input logic [19:0] s, input logic [19:0] d, input int nw, input int nr);
		int w0;
		int r0;
		w0 = mem.wn;
		r0 = mem.rc;
		reg_wr(0, OFS_CTRL, 32'h0000_0000); // unlock fixed pointers
		reg_wr(0, OFS_SRC, 32'(s));
		reg_wr(0, OFS_DST, 32'(d));
		reg_wr(0, OFS_RELOAD, 32'h0000_0000);
		reg_wr(0, OFS_CTRL, EN | SF | S7);
		pulse(20'h0_0004);
		quiet();
		chk(32'(mem.wn - w0), 32'(nw)); // write count
		chk(32'(mem.rc - r0), 32'(nr)); // read cycles
		if (nw > 0) begin
			chk(32'(mem.wa[w0]), 32'(d)); // target
		end
		if (nw == 1) begin
			chk(32'(mem.wd[w0]), {16'h0000, bv(s + 20'h0_0001), bv(s)}); // word
		end
		if (nw == 2) begin
			chk(32'(mem.wd[w0]), {24'h00_0000, bv(s)}); // low byte first
			chk(32'(mem.wa[w0 + 1]), 32'(d + 20'h0_0001)); // next byte
			chk(32'(mem.wd[w0 + 1]), {24'h00_0000, bv(s + 20'h0_0001)}); // high byte
		end
	endtask

	initial begin
		int w0;
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
		pin0 = 1'b1;
		pin1 = 1'b1;
		periph = 20'h0_0000;
		byte_pin = 1'b0;
		exp_mode = 1'b0;
		sw_wait = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(0, OFS_CTRL, 32'h0000_0000);
		reg_rd(1, OFS_COUNT, 32'h0000_0000);
		reg_wr(3'b110, OFS_SRC, 32'h0000_1234);
		reg_rd(3'b110, OFS_SRC, 32'h0000_0000);
		reg_wr(0, OFS_CTRL, SW);
		reg_rd(0, OFS_CTRL, RQ); // set by trigger
		chk(32'(mem.wn), 32'h0000_0000); // disabled idle
		reg_wr(0, OFS_CTRL, 32'h0000_0000);
		reg_rd(0, OFS_CTRL, 32'h0000_0000); // software clear
		reg_wr(0, OFS_SRC, 32'h0000_1000);
		reg_wr(0, OFS_DST, 32'h0000_2000);
		reg_wr(0, OFS_RELOAD, 32'h0000_0001);
		reg_wr(0, OFS_CTRL, EN | SF | S7);
		pulse(20'h0_0004);
		quiet();
		reg_rd(0, OFS_SRC, 32'h0000_1002); // live pointer
		reg_rd(0, OFS_COUNT, 32'h0000_0000); // one step down
		reg_wr(0, OFS_DST, 32'h0000_3000);
		reg_rd(0, OFS_DST, 32'h0000_2000); // fixed locked
		chk(32'(irq0), 32'h0000_0000); // no early pulse
		pulse(20'h0_0004);
		quiet();
		chk(32'(irq0), 32'h0000_0001); // underflow pulse
		reg_rd(0, OFS_CTRL, SF | S7); // enable dropped
		chk(32'(mem.wd[mem.wn - 1]), {16'h0000, bv(20'h0_1003), bv(20'h0_1002)}); // advance
		pulse(20'h0_0004);
		quiet();
		chk(32'(mem.wn), 32'h0000_0002); // inactive after run
		reg_wr(1, OFS_SRC, 32'h0000_1100);
		reg_wr(1, OFS_DST, 32'h0000_4000);
		reg_wr(1, OFS_RELOAD, 32'h0000_0000);
		reg_wr(1, OFS_CTRL, EN | RP | DF | S6);
		repeat (2) begin
			pulse(20'h0_0002);
			quiet();
			chk(32'(mem.wa[mem.wn - 1]), 32'h0000_4000); // pointer reloaded
		end
		chk(32'(irq1), 32'h0000_0002); // pulse per underflow
		reg_rd(1, OFS_CTRL, EN | RP | DF | S6); // stays active
		w0 = mem.wn;
		w0 = w0 - mem.ownr;
		reg_wr(0, OFS_CTRL, EN | SF | S7);
		pulse(20'h0_0006);
		quiet();
		chk(32'(mem.wa[mem.wn - 2]), 32'h0000_2000); // zero first
		chk(32'(mem.wa[mem.wn - 1]), 32'h0000_4000); // one second
		chk(32'(mem.wn - mem.ownr - w0), 32'h0000_0000); // bus released between
		w0 = mem.wn;
		// Selection applies a cycle later, so select soft first
		reg_wr(0, OFS_CTRL, EN | SF); // select software
		reg_wr(0, OFS_CTRL, EN | SF | SW);
		quiet();
		chk(32'(mem.wn - w0), 32'h0000_0001); // software start
		reg_wr(0, OFS_CTRL, EN | SF | SP0);
		reg_wr(1, OFS_CTRL, EN | RP | DF | S0B); // pin zero both edges
		pin0 <= 1'b0;
		quiet();
		pin0 <= 1'b1;
		quiet();
		chk(32'(mem.wn - w0), 32'h0000_0004); // fall on both, rise on one only
		chk(32'(mem.wa[mem.wn - 1]), 32'h0000_4000); // rise served channel one
		// Pin one: channel zero both edges in byte units, channel one falling only
		w0 = mem.wn;
		reg_wr(0, OFS_RELOAD, 32'h0000_0004);
		reg_wr(0, OFS_CTRL, EN | RP | SF | U8 | S1B);
		reg_wr(1, OFS_CTRL, EN | RP | DF | S1F);
		pin1 <= 1'b0;
		quiet();
		pin1 <= 1'b1;
		quiet();
		chk(32'(mem.wn - w0), 32'h0000_0003); // pin one edges
		chk(32'(mem.wd[mem.wn - 1]), {24'h00_0000, bv(20'h0_1001)}); // byte unit
		reg_rd(0, OFS_SRC, 32'h0000_1002); // byte step
		reg_rd(0, OFS_COUNT, 32'h0000_0002); // two steps down
		one0(20'h0_1000, 20'h0_2000, 1, 1);
		one0(20'h0_1001, 20'h0_2003, 2, 2); // odd both
		one0(20'h0_0100, 20'h0_2000, 1, 2); // special area
		one0(20'h0_1000, 20'h0_0030, 0, 1); // own range
		sw_wait <= 1'b1;
		one0(20'h0_1000, 20'h0_2000, 1, 2); // software wait
		sw_wait <= 1'b0;
		byte_pin <= 1'b1;
		exp_mode <= 1'b1;
		one0(20'h0_1010, 20'h0_2010, 2, 2); // narrow bus
		results();
	end
endmodule
